// >>> shared/pr_seq_pkg.sv
package pr_seq_pkg;

    localparam int DATA_W   = 32;
    localparam int REGIONS  = 4;
    localparam int REGION_W = 2;
    localparam int FUNC_W   = 4;

    // Image source ports
    localparam logic [1:0] PORT_INTERNAL  = 2'h0;
    localparam logic [1:0] PORT_PARALLEL  = 2'h1;
    localparam logic [1:0] PORT_PROCESSOR = 2'h2;
    localparam logic [1:0] PORT_PCIE      = 2'h3;

    // Word formatting on the byte-oriented ports
    localparam logic [1:0] FMT_BYTE = 2'h0;
    localparam logic [1:0] FMT_HALF = 2'h1;
    localparam logic [1:0] FMT_WORD = 2'h2;

    // Device families
    localparam logic [1:0] FAMILY_OLDER     = 2'h0;
    localparam logic [1:0] FAMILY_FIRST_GEN = 2'h1;
    localparam logic [1:0] FAMILY_ENHANCED  = 2'h2;
    localparam logic [1:0] FAMILY_PROC      = 2'h3;

    // Readback security level that locks the parallel port
    localparam logic [1:0] SECURITY_TOP = 2'h2;

    // Reset values
    localparam logic [REGIONS-1:0] MASK_RST     = 4'h0;
    localparam logic [FUNC_W-1:0]  RESIDENT_RST = 4'h0;
    localparam logic [1:0]         FAMILY_RST   = 2'h0;
    localparam logic [1:0]         SECURITY_RST = 2'h0;

    typedef enum logic [3:0] {
        S_IDLE = 4'h1,
        S_LOAD = 4'h2,
        S_DROP = 4'h4,
        S_DONE = 4'h8
    } seq_e;

    function automatic logic [DATA_W-1:0] swap_bits(input logic [DATA_W-1:0] d);
        logic [DATA_W-1:0] r;
        r = '0;
        for (int i = 0; i < DATA_W; i++) begin
            r[i] = d[(i / 8) * 8 + 7 - (i % 8)];
        end
        return r;
    endfunction

endpackage

// >>> verilog/word_packer.sv
`timescale 1ns/1ps
module word_packer (
    input  wire logic        clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        clear_in,
    input  wire logic        beat_in,
    input  wire logic        last_in,
    input  wire logic [31:0] data_in,
    input  wire logic [1:0]  format_in,
    input  wire logic        swap_in,
    output logic      [31:0] word_out,
    output logic             word_valid_out
);
    logic [1:0]  count_q;
    logic [1:0]  count_d;
    logic [31:0] acc_q;
    logic [31:0] acc_d;
    logic [31:0] word_q;
    logic [31:0] word_d;
    logic        valid_q;
    logic        valid_d;

    always_comb begin
        logic [31:0] d;
        logic [31:0] acc_n;
        logic [1:0]  top;
        d       = swap_in ? pr_seq_pkg::swap_bits(data_in) : data_in;
        acc_n   = d;
        top     = 2'h0;
        count_d = count_q;
        acc_d   = acc_q;
        word_d  = word_q;
        valid_d = 1'b0;
        unique case (format_in)
            pr_seq_pkg::FMT_BYTE: begin
                acc_n = {acc_q[23:0], d[7:0]};
                top   = 2'h3;
            end
            pr_seq_pkg::FMT_HALF: begin
                acc_n = {acc_q[15:0], d[15:0]};
                top   = 2'h1;
            end
            default: begin
                acc_n = d;
                top   = 2'h0;
            end
        endcase
        if (clear_in) begin
            count_d = 2'h0;
            acc_d   = 32'h0;
        end else if (beat_in) begin
            // Short final word leaves its bytes low-aligned
            if (count_q == top || last_in) begin
                word_d  = acc_n;
                valid_d = 1'b1;
                count_d = 2'h0;
                acc_d   = 32'h0;
            end else begin
                acc_d   = acc_n;
                count_d = count_q + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count_q <= 2'h0;
            acc_q   <= 32'h0;
            word_q  <= 32'h0;
            valid_q <= 1'b0;
        end else begin
            count_q <= count_d;
            acc_q   <= acc_d;
            word_q  <= word_d;
            valid_q <= valid_d;
        end
    end

    assign word_out       = word_q;
    assign word_valid_out = valid_q;
endmodule

// >>> verilog/pr_delivery_seq.sv
// Notes on behaviour
// - Clearing opens mask; partial initialises, closes it.
// - No prior clearing image: initialisation does nothing.
// - Other region cleared: that region gets initialised.
// - Wrong-function clearing flags disruption until a partial image loads that region.
// - Partial image accepted without announcing command.
// - Internal port uses parallel slave word protocol.
// - Parallel port refused at top security level.
// - Clearing scheme applies to first-generation family only.
`timescale 1ns/1ps
module pr_delivery_seq (
    input  wire logic        CLK_IN,
    input  wire logic        ARST_N_IN,
    input  wire logic [1:0]  FAMILY_IN,
    input  wire logic [1:0]  SECURITY_LEVEL_IN,
    input  wire logic [1:0]  PORT_SEL_IN,
    input  wire logic [1:0]  FORMAT_IN,
    input  wire logic        IMAGE_START_IN,
    input  wire logic        IMAGE_CLEAR_IN,
    input  wire logic [1:0]  IMAGE_REGION_IN,
    input  wire logic [3:0]  IMAGE_FUNC_IN,
    input  wire logic [31:0] DATA_IN,
    input  wire logic        DATA_VALID_IN,
    input  wire logic        DATA_LAST_IN,
    output logic             DATA_READY_OUT,
    output logic      [31:0] CFG_DATA_OUT,
    output logic             CFG_VALID_OUT,
    output logic      [3:0]  MASK_OUT,
    output logic      [3:0]  INIT_REGION_OUT,
    output logic      [3:0]  DISRUPT_OUT,
    output logic             REFUSED_OUT,
    output logic             BUSY_OUT
);
    localparam int NR = pr_seq_pkg::REGIONS;
    localparam int FW = pr_seq_pkg::FUNC_W;

    // Straps come from pins, so they are synchronised first
    logic [1:0] fam_meta_q;
    logic [1:0] fam_q;
    logic [1:0] sec_meta_q;
    logic [1:0] sec_q;

    pr_seq_pkg::seq_e state_q;
    pr_seq_pkg::seq_e state_d;
    logic          clear_img_q;
    logic          clear_img_d;
    logic [1:0]    region_q;
    logic [1:0]    region_d;
    logic [FW-1:0] func_q;
    logic [FW-1:0] func_d;
    logic [1:0]    port_q;
    logic [1:0]    port_d;
    logic [1:0]    fmt_q;
    logic [1:0]    fmt_d;
    logic [NR-1:0] mask_q;
    logic [NR-1:0] mask_d;
    logic [NR-1:0] disrupt_q;
    logic [NR-1:0] disrupt_d;
    logic [NR-1:0] init_q;
    logic [NR-1:0] init_d;
    logic          refused_q;
    logic          refused_d;
    logic          clr_valid_q;
    logic          clr_valid_d;
    logic [1:0]    clr_region_q;
    logic [1:0]    clr_region_d;
    logic [FW-1:0] resident_q [NR];
    logic [FW-1:0] resident_d [NR];
    logic          needs_clear;
    logic          swap;
    logic [1:0]    eff_fmt;
    logic          beat;

    assign needs_clear = (fam_q == pr_seq_pkg::FAMILY_FIRST_GEN);
    // Internal and parallel ports share one word path and bit order
    assign swap = (port_q == pr_seq_pkg::PORT_INTERNAL) ||
                  (port_q == pr_seq_pkg::PORT_PARALLEL);
    assign eff_fmt = swap ? fmt_q : pr_seq_pkg::FMT_WORD;
    assign beat    = DATA_VALID_IN && (state_q == pr_seq_pkg::S_LOAD);

    always_comb begin
        state_d      = state_q;
        clear_img_d  = clear_img_q;
        region_d     = region_q;
        func_d       = func_q;
        port_d       = port_q;
        fmt_d        = fmt_q;
        mask_d       = mask_q;
        disrupt_d    = disrupt_q;
        init_d       = '0;
        refused_d    = 1'b0;
        clr_valid_d  = clr_valid_q;
        clr_region_d = clr_region_q;
        resident_d   = resident_q;
        unique case (state_q)
            pr_seq_pkg::S_IDLE: begin
                // Any start is taken as-is; no partial-mode command exists
                if (IMAGE_START_IN) begin
                    clear_img_d = IMAGE_CLEAR_IN;
                    region_d    = IMAGE_REGION_IN;
                    func_d      = IMAGE_FUNC_IN;
                    port_d      = PORT_SEL_IN;
                    fmt_d       = FORMAT_IN;
                    if (PORT_SEL_IN == pr_seq_pkg::PORT_PARALLEL &&
                        sec_q >= pr_seq_pkg::SECURITY_TOP) begin
                        refused_d = 1'b1;
                        state_d   = pr_seq_pkg::S_DROP;
                    end else begin
                        state_d   = pr_seq_pkg::S_LOAD;
                    end
                end
            end
            pr_seq_pkg::S_LOAD: begin
                if (DATA_VALID_IN && DATA_LAST_IN) begin
                    state_d = pr_seq_pkg::S_DONE;
                end
            end
            pr_seq_pkg::S_DROP: begin
                // Refused image is swallowed so the controller never hangs
                if (DATA_VALID_IN && DATA_LAST_IN) begin
                    state_d = pr_seq_pkg::S_IDLE;
                end
            end
            pr_seq_pkg::S_DONE: begin
                state_d = pr_seq_pkg::S_IDLE;
                if (clear_img_q) begin
                    if (needs_clear) begin
                        mask_d[region_q] = 1'b1;
                        clr_valid_d      = 1'b1;
                        clr_region_d     = region_q;
                        if (func_q != resident_q[region_q]) begin
                            disrupt_d[region_q] = 1'b1;
                        end
                    end
                end else begin
                    resident_d[region_q] = func_q;
                    disrupt_d[region_q]  = 1'b0;
                    if (!needs_clear) begin
                        init_d[region_q] = 1'b1;
                    end else if (clr_valid_q) begin
                        // Initialisation follows the opened mask, not the image
                        init_d[clr_region_q] = 1'b1;
                        mask_d[clr_region_q] = 1'b0;
                        clr_valid_d          = 1'b0;
                    end
                    // In the clearing family, without an open mask nothing is initialised
                end
            end
            default: begin
                state_d = pr_seq_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
        if (!ARST_N_IN) begin
            fam_meta_q   <= pr_seq_pkg::FAMILY_RST;
            fam_q        <= pr_seq_pkg::FAMILY_RST;
            sec_meta_q   <= pr_seq_pkg::SECURITY_RST;
            sec_q        <= pr_seq_pkg::SECURITY_RST;
            state_q      <= pr_seq_pkg::S_IDLE;
            clear_img_q  <= 1'b0;
            region_q     <= 2'h0;
            func_q       <= pr_seq_pkg::RESIDENT_RST;
            port_q       <= pr_seq_pkg::PORT_INTERNAL;
            fmt_q        <= pr_seq_pkg::FMT_BYTE;
            mask_q       <= pr_seq_pkg::MASK_RST;
            disrupt_q    <= pr_seq_pkg::MASK_RST;
            init_q       <= pr_seq_pkg::MASK_RST;
            refused_q    <= 1'b0;
            clr_valid_q  <= 1'b0;
            clr_region_q <= 2'h0;
            for (int i = 0; i < NR; i++) begin
                resident_q[i] <= pr_seq_pkg::RESIDENT_RST;
            end
        end else begin
            fam_meta_q   <= FAMILY_IN;
            fam_q        <= fam_meta_q;
            sec_meta_q   <= SECURITY_LEVEL_IN;
            sec_q        <= sec_meta_q;
            state_q      <= state_d;
            clear_img_q  <= clear_img_d;
            region_q     <= region_d;
            func_q       <= func_d;
            port_q       <= port_d;
            fmt_q        <= fmt_d;
            mask_q       <= mask_d;
            disrupt_q    <= disrupt_d;
            init_q       <= init_d;
            refused_q    <= refused_d;
            clr_valid_q  <= clr_valid_d;
            clr_region_q <= clr_region_d;
            resident_q   <= resident_d;
        end
    end

    word_packer u_packer (
        .clk_in         (CLK_IN),
        .arst_n_in      (ARST_N_IN),
        .clear_in       (state_q == pr_seq_pkg::S_IDLE),
        .beat_in        (beat),
        .last_in        (DATA_LAST_IN),
        .data_in        (DATA_IN),
        .format_in      (eff_fmt),
        .swap_in        (swap),
        .word_out       (CFG_DATA_OUT),
        .word_valid_out (CFG_VALID_OUT)
    );

    assign DATA_READY_OUT  = (state_q == pr_seq_pkg::S_LOAD) || (state_q == pr_seq_pkg::S_DROP);
    assign MASK_OUT        = mask_q;
    assign INIT_REGION_OUT = init_q;
    assign DISRUPT_OUT     = disrupt_q;
    assign REFUSED_OUT     = refused_q;
    assign BUSY_OUT        = (state_q != pr_seq_pkg::S_IDLE);

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!ARST_N_IN);

    logic done_clr;
    logic done_part;
    assign done_clr  = (state_q == pr_seq_pkg::S_DONE) && clear_img_q;
    assign done_part = (state_q == pr_seq_pkg::S_DONE) && !clear_img_q;

    mask_opens_a: assert property (done_clr && needs_clear
        |=> MASK_OUT[$past(region_q)])
        else $error("Clearing image did not open the region mask");
    mask_closes_a: assert property (done_part && needs_clear && clr_valid_q
        |=> !MASK_OUT[$past(clr_region_q)] && !clr_valid_q)
        else $error("Partial image did not close the mask");
    no_init_a: assert property (done_part && needs_clear && !clr_valid_q
        |=> INIT_REGION_OUT == 4'h0)
        else $error("Initialisation without prior clearing image");
    other_region_a: assert property (done_part && needs_clear && clr_valid_q
        |=> INIT_REGION_OUT == (4'h1 << $past(clr_region_q)))
        else $error("Initialisation went to the wrong region");
    disrupt_flag_a: assert property (done_clr && needs_clear
        && func_q != resident_q[region_q] |=> DISRUPT_OUT[$past(region_q)])
        else $error("Wrong-function clearing not flagged");
    start_taken_a: assert property (state_q == pr_seq_pkg::S_IDLE && IMAGE_START_IN
        && PORT_SEL_IN != pr_seq_pkg::PORT_PARALLEL |=> DATA_READY_OUT && !REFUSED_OUT)
        else $error("Partial image not accepted");
    shared_path_a: assert property (CFG_VALID_OUT |-> $past(beat))
        else $error("Configuration word without a loaded beat");
    secure_refuse_a: assert property (IMAGE_START_IN
        && state_q == pr_seq_pkg::S_IDLE && PORT_SEL_IN == pr_seq_pkg::PORT_PARALLEL
        && sec_q >= pr_seq_pkg::SECURITY_TOP
        |=> REFUSED_OUT ##1 !REFUSED_OUT && !CFG_VALID_OUT)
        else $error("External port not refused at top security level");
    family_init_a: assert property (done_part && !needs_clear
        |=> INIT_REGION_OUT == (4'h1 << $past(region_q))
        && MASK_OUT == $past(MASK_OUT))
        else $error("Non-clearing family did not initialise the loaded region");

    swap_cover_c:    cover property (done_clr ##[1:200] done_part);
    refuse_cover_c:  cover property (REFUSED_OUT);
    disrupt_cover_c: cover property (DISRUPT_OUT != 4'h0);
    other_cover_c:   cover property (done_part && clr_valid_q && clr_region_q != region_q);
endmodule

// >>> tb/pr_ctrl_model.sv
`timescale 1ns/1ps
module pr_ctrl_model (
    input  wire logic        clk_in,
    input  wire logic        ready_in,
    input  wire logic        busy_in,
    output logic             start_out,
    output logic             clear_out,
    output logic      [1:0]  region_out,
    output logic      [3:0]  func_out,
    output logic      [1:0]  port_out,
    output logic      [1:0]  format_out,
    output logic      [31:0] data_out,
    output logic             valid_out,
    output logic             last_out
);
    int stalls = 0;

    // No restart or clear pin in this model at all
    // Quiescing belongs to user logic, never to these lines
    // Images are plain, so no key applies; only the security level limits ports
    initial begin
        {start_out, clear_out, region_out, func_out, port_out, format_out} = '0;
        {valid_out, last_out} = 2'h0;
        data_out = 32'h0;
    end

    // Bounded wait, judged at the falling edge where the answer has settled
    task automatic settle(input logic want_ready);
        int n;
        n = 0;
        @(negedge clk_in);
        while ((want_ready ? ready_in : !busy_in) !== 1'b1 && n < 100) begin
            @(negedge clk_in);
            n++;
        end
        if (n == 100) stalls++;
        @(posedge clk_in);
    endtask

    // Same sequencing on every port
    // Beat content already formatted for port width and bit order
    // Byte-wide beats when the caller asks for them
    // Gap 0 keeps the port saturated, one beat per clock
    task automatic send(input logic [1:0] port, input logic [1:0] fmt, input logic clr,
                        input logic [1:0] rg, input logic [3:0] fn, input int n,
                        input logic [127:0] d, input int gap);
        settle(1'b0);
        #1;
        {port_out, format_out, clear_out, region_out, func_out} = {port, fmt, clr, rg, fn};
        start_out = 1'b1;
        @(posedge clk_in);
        #1;
        start_out = 1'b0;
        for (int i = 0; i < n; i++) begin
            data_out = d[127-32*i -: 32];
            last_out = (i == n - 1);
            valid_out = 1'b1;
            settle(1'b1);
            #1;
            // Released bus shows the inverse, not a stale beat
            if (gap > 0 || i == n - 1) begin
                valid_out = 1'b0;
                last_out = 1'b0;
                data_out = ~data_out;
            end
            repeat (gap) begin
                @(posedge clk_in);
                #1;
            end
        end
    endtask
endmodule

// >>> tb/test_pr_delivery_seq.sv
`timescale 1ns/1ps
module test_pr_delivery_seq;
    localparam logic [31:0] D1 = 32'h8421_0F3C;
    localparam logic [127:0] D4 = 128'hFFFFFFA1_000000B2_5A5A5AC3_000000D4;
    localparam logic [127:0] D3 = 128'hEEEEEEA1_000000B2_000000C3_00000000;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [1:0]  family = 2'h0;
    logic [1:0]  security = 2'h0;
    logic        start, clr, valid, last, ready, busy, cfg_valid, refused;
    logic [1:0]  region, port, fmt;
    logic [3:0]  func, mask, init_reg, disrupt;
    logic [31:0] data, cfg_data, last_w;
    logic [3:0]  init_acc = 4'h0;
    int          n_w = 0;
    int          n_ref = 0;
    int          bad_count = 0;
    int          n_tests = 0;

    always #12.5 clk = ~clk;

    pr_delivery_seq pr_delivery_seq_inst (
        .CLK_IN(clk), .ARST_N_IN(arst_n), .FAMILY_IN(family), .SECURITY_LEVEL_IN(security),
        .PORT_SEL_IN(port), .FORMAT_IN(fmt), .IMAGE_START_IN(start), .IMAGE_CLEAR_IN(clr),
        .IMAGE_REGION_IN(region), .IMAGE_FUNC_IN(func), .DATA_IN(data),
        .DATA_VALID_IN(valid), .DATA_LAST_IN(last), .DATA_READY_OUT(ready),
        .CFG_DATA_OUT(cfg_data), .CFG_VALID_OUT(cfg_valid), .MASK_OUT(mask),
        .INIT_REGION_OUT(init_reg), .DISRUPT_OUT(disrupt), .REFUSED_OUT(refused),
        .BUSY_OUT(busy));

    pr_ctrl_model pr_ctrl_model_inst (
        .clk_in(clk), .ready_in(ready), .busy_in(busy), .start_out(start), .clear_out(clr),
        .region_out(region), .func_out(func), .port_out(port), .format_out(fmt),
        .data_out(data), .valid_out(valid), .last_out(last));

    // Pulses last one cycle, so they are gathered here as they pass
    always @(posedge clk) begin
        if (cfg_valid === 1'b1) begin
            n_w++;
            last_w = cfg_data;
        end
        init_acc = init_acc | init_reg;
        if (refused === 1'b1) n_ref++;
    end

    function automatic logic [31:0] flip(input logic [31:0] d);
        logic [31:0] r;
        for (int i = 0; i < 32; i++) r[i] = d[i - i % 8 + 7 - i % 8];
        return r;
    endfunction

    task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cmp4(input string nm, input logic [3:0] e, input logic [3:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic conclude;
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Straps get three edges past release to clear the synchroniser
    task automatic do_reset(input logic [1:0] fam, input logic [1:0] sec);
        arst_n = 1'b0;
        family = fam;
        security = sec;
        repeat (12) @(posedge clk);
        #1;
        arst_n = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        n_w = 0;
        init_acc = 4'h0;
        n_ref = 0;
    endtask

    task automatic img(input logic [1:0] p, input logic [1:0] f, input logic c,
                       input logic [1:0] rg, input logic [3:0] fn, input int n,
                       input logic [127:0] d, input int gap);
        pr_ctrl_model_inst.send(p, f, c, rg, fn, n, d, gap);
    endtask

    task automatic one(input logic c, input logic [1:0] rg, input logic [3:0] fn);
        img(pr_seq_pkg::PORT_PROCESSOR, pr_seq_pkg::FMT_WORD, c, rg, fn, 1, {D1, 96'h0}, 0);
    endtask

    task automatic check(input int nw, input logic [31:0] w, input logic [3:0] ini,
                         input logic [3:0] msk, input logic [3:0] dis);
        repeat (4) @(posedge clk);
        #1;
        cmp32("words", 32'(nw), 32'(n_w));
        if (nw > 0) cmp32("cfg_data", w, last_w);
        cmp4("init", ini, init_acc);
        cmp4("mask", msk, mask);
        cmp4("disrupt", dis, disrupt);
        n_w = 0;
        init_acc = 4'h0;
    endtask

    task automatic t_ports;
        do_reset(pr_seq_pkg::FAMILY_ENHANCED, pr_seq_pkg::SECURITY_RST);
        for (int p = 0; p < 4; p++) begin
            img(2'(p), p >= 2 ? 2'h0 : 2'h2, 1'b0, 2'h1, 4'h1, 1, {D1, 96'h0}, 0);
            check(1, p >= 2 ? D1 : flip(D1), 4'h2, 4'h0, 4'h0);
        end
        img(2'h0, pr_seq_pkg::FMT_WORD, 1'b1, 2'h1, 4'h1, 1, {D1, 96'h0}, 0);
        check(1, flip(D1), 4'h0, 4'h0, 4'h0);
    endtask

    task automatic t_formats;
        do_reset(pr_seq_pkg::FAMILY_OLDER, pr_seq_pkg::SECURITY_RST);
        img(2'h0, 2'h0, 1'b0, 2'h0, 4'h3, 4, D4, 1);
        check(1, flip(32'hA1B2_C3D4), 4'h1, 4'h0, 4'h0);
        img(2'h1, 2'h1, 1'b0, 2'h0, 4'h3, 2, {64'hFFFF1357_00009BDF, 64'h0}, 0);
        check(1, flip(32'h1357_9BDF), 4'h1, 4'h0, 4'h0);
        img(2'h0, 2'h0, 1'b0, 2'h0, 4'h3, 3, D3, 0);
        check(1, flip(32'h00A1_B2C3), 4'h1, 4'h0, 4'h0);
    endtask

    // Resident function of every region is 0 after reset
    task automatic t_clear;
        do_reset(pr_seq_pkg::FAMILY_FIRST_GEN, pr_seq_pkg::SECURITY_RST);
        one(1'b1, 2'h2, 4'h0);
        check(1, D1, 4'h0, 4'h4, 4'h0);
        one(1'b0, 2'h2, 4'h7);
        check(1, D1, 4'h4, 4'h0, 4'h0);
        one(1'b0, 2'h2, 4'h7);
        check(1, D1, 4'h0, 4'h0, 4'h0);
        one(1'b1, 2'h3, 4'h0);
        check(1, D1, 4'h0, 4'h8, 4'h0);
        one(1'b0, 2'h0, 4'h9);
        check(1, D1, 4'h8, 4'h0, 4'h0);
    endtask

    task automatic t_wrong;
        do_reset(pr_seq_pkg::FAMILY_FIRST_GEN, pr_seq_pkg::SECURITY_RST);
        one(1'b1, 2'h1, 4'h5);
        check(1, D1, 4'h0, 4'h2, 4'h2);
        one(1'b0, 2'h1, 4'h5);
        check(1, D1, 4'h2, 4'h0, 4'h0);
    endtask

    task automatic t_refuse;
        do_reset(pr_seq_pkg::FAMILY_OLDER, pr_seq_pkg::SECURITY_TOP);
        img(2'h1, 2'h2, 1'b0, 2'h3, 4'h1, 2, {D1, ~D1, 64'h0}, 0);
        check(0, D1, 4'h0, 4'h0, 4'h0);
        cmp32("refused", 32'h1, 32'(n_ref));
        img(2'h0, 2'h2, 1'b0, 2'h3, 4'h1, 2, {D1, ~D1, 64'h0}, 0);
        check(2, flip(~D1), 4'h8, 4'h0, 4'h0);
        do_reset(pr_seq_pkg::FAMILY_PROC, 2'h1);
        img(2'h1, 2'h2, 1'b0, 2'h3, 4'h1, 2, {D1, ~D1, 64'h0}, 0);
        check(2, flip(~D1), 4'h8, 4'h0, 4'h0);
        cmp32("refused", 32'h0, 32'(n_ref));
    endtask

    initial begin
        t_ports();
        t_formats();
        t_clear();
        t_wrong();
        t_refuse();
        cmp32("stalls", 32'h0, 32'(pr_ctrl_model_inst.stalls));
        conclude();
    end

    // Whole run is well under 2000 cycles; 20000 means a hang
    initial begin
        #500000;
        bad_count++;
        conclude();
    end
endmodule
